// [amc_mode_ctrl.sv]
`timescale 1ns/1ps
module amc_mode_ctrl #(
    parameter int unsigned CLK_IN_HZ = amc_pkg::APPLIED_CLK_HZ
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic reset_pin_active_low,
    input wire logic power_down_pin,
    input wire logic spi_sclk,
    input wire logic spi_sdata,
    input wire logic spi_cs_n,
    output logic power_down,
    output logic [1:0] mode_active,
    output logic [7:0] clk_div_active,
    output logic [3:0] mode_divisor,
    output logic [4:0] word_bits,
    output logic [1:0] bclk_phase,
    output logic [7:0] ch_input_sel,
    output logic route_ok,
    output logic [31:0] sample_frequency,
    output logic [31:0] bit_rate,
    output logic [31:0] lclk_rate
);
    amc_cfg_if cfg ();

    amc_spi_rx u_spi_rx (
        .clk_sys(clk_sys),
        .rst(rst),
        .spi_sclk(spi_sclk),
        .spi_sdata(spi_sdata),
        .spi_cs_n(spi_cs_n),
        .cfg(cfg)
    );

    function automatic logic [2:0] input_index(input logic [7:0] code);
        unique case (code)
            amc_pkg::IN1_CODE: input_index = 3'h4;
            amc_pkg::IN2_CODE: input_index = 3'h5;
            amc_pkg::IN3_CODE: input_index = 3'h6;
            amc_pkg::IN4_CODE: input_index = 3'h7;
            default: input_index = 3'h0;
        endcase
    endfunction

    function automatic logic [1:0] nb_shift(input amc_pkg::amc_mode_t m);
        unique case (m)
            amc_pkg::AMC_MODE_SINGLE: nb_shift = amc_pkg::NB_SHIFT_SINGLE;
            amc_pkg::AMC_MODE_DUAL: nb_shift = amc_pkg::NB_SHIFT_DUAL;
            amc_pkg::AMC_MODE_QUAD: nb_shift = amc_pkg::NB_SHIFT_QUAD;
            amc_pkg::AMC_MODE_PRECISION: nb_shift = amc_pkg::NB_SHIFT_QUAD;
        endcase
    endfunction

    // Pin synchronisers
    logic rstn_meta_reg, rstn_sync_reg;
    logic pd_meta_reg, pd_sync_reg, pd_prev_reg;

    always_ff @(posedge clk_sys) begin
        rstn_meta_reg <= reset_pin_active_low;
        rstn_sync_reg <= rstn_meta_reg;
        pd_meta_reg <= power_down_pin;
        pd_sync_reg <= pd_meta_reg;
        pd_prev_reg <= rst ? 1'b0 : pd_sync_reg;
    end

    logic soft_rst, dev_rst;
    logic wr_power, wr_mode, wr_route_a, wr_route_b, wr_phase, wr_format;

    assign soft_rst = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_SOFT_RESET
        && cfg.data == amc_pkg::VAL_SOFT_RESET;
    // Pin held low keeps the configuration at defaults until it rises
    assign dev_rst = rst || !rstn_sync_reg || soft_rst;
    assign wr_power = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_POWER;
    assign wr_mode = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_MODE;
    assign wr_route_a = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_ROUTE_A;
    assign wr_route_b = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_ROUTE_B;
    assign wr_phase = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_PHASE;
    assign wr_format = cfg.wr_stb && cfg.addr == amc_pkg::ADDR_FORMAT;

    // Configuration registers
    logic [15:0] power_state_ctrl_reg, power_state_ctrl_next;
    logic [15:0] mode_and_clock_divider_reg, mode_and_clock_divider_next;
    logic [15:0] input_route_ch1_ch2_reg, input_route_ch1_ch2_next;
    logic [15:0] input_route_ch3_ch4_reg, input_route_ch3_ch4_next;
    logic [15:0] bit_clock_phase_reg, bit_clock_phase_next;
    logic [15:0] output_word_format_reg, output_word_format_next;
    logic pd_state_reg, pd_state_next;
    amc_pkg::amc_mode_t mode_act_reg, mode_act_next;
    logic [7:0] div_act_reg, div_act_next;
    logic [7:0] ch_sel_reg, ch_sel_next;
    logic route_ok_reg, route_ok_next;
    logic [4:0] word_bits_reg, word_bits_next;

    always_comb begin
        logic [2:0] a_hi, a_lo, b_hi, b_lo;
        a_hi = 3'h0;
        a_lo = 3'h0;
        b_hi = 3'h0;
        b_lo = 3'h0;
        power_state_ctrl_next = power_state_ctrl_reg;
        mode_and_clock_divider_next = mode_and_clock_divider_reg;
        input_route_ch1_ch2_next = input_route_ch1_ch2_reg;
        input_route_ch3_ch4_next = input_route_ch3_ch4_reg;
        bit_clock_phase_next = bit_clock_phase_reg;
        output_word_format_next = output_word_format_reg;
        pd_state_next = pd_state_reg;
        mode_act_next = mode_act_reg;
        div_act_next = div_act_reg;
        if (dev_rst) begin
            power_state_ctrl_next = amc_pkg::RST_POWER;
            mode_and_clock_divider_next = amc_pkg::RST_MODE;
            input_route_ch1_ch2_next = amc_pkg::RST_ROUTE;
            input_route_ch3_ch4_next = amc_pkg::RST_ROUTE;
            bit_clock_phase_next = amc_pkg::RST_PHASE;
            output_word_format_next = amc_pkg::RST_FORMAT;
            // A pin already high keeps the device down through reset
            pd_state_next = pd_sync_reg;
        end else begin
            if (wr_power) begin
                power_state_ctrl_next = cfg.data;
                pd_state_next = cfg.data[amc_pkg::PD_BIT];
            end
            // Pin edges act like writes; a pin edge wins a same-cycle write
            if (pd_sync_reg && !pd_prev_reg) begin
                pd_state_next = 1'b1;
            end else if (!pd_sync_reg && pd_prev_reg) begin
                pd_state_next = 1'b0;
            end
            if (wr_mode) begin
                mode_and_clock_divider_next = cfg.data;
            end
            if (wr_route_a) begin
                input_route_ch1_ch2_next = cfg.data;
            end
            if (wr_route_b) begin
                input_route_ch3_ch4_next = cfg.data;
            end
            if (wr_phase) begin
                bit_clock_phase_next = cfg.data;
            end
            if (wr_format) begin
                output_word_format_next = cfg.data;
            end
        end
        // Mode and divider are taken over only while powered down or in reset, since
        // the converter resynchronises its interleaving on wake.
        if (pd_state_reg || dev_rst) begin
            mode_act_next = amc_pkg::amc_mode_t'(mode_and_clock_divider_next[
                amc_pkg::MODE_LSB +: amc_pkg::MODE_W]);
            div_act_next = mode_and_clock_divider_next[
                amc_pkg::DIV_LSB +: amc_pkg::DIV_W];
        end
        // Routing is decoded from the next values so a new selection
        // lands at the same edge that stores the write.
        a_hi = input_index(input_route_ch1_ch2_next[
            amc_pkg::ROUTE_HI_LSB +: 8]);
        a_lo = input_index(input_route_ch1_ch2_next[
            amc_pkg::ROUTE_LO_LSB +: 8]);
        b_hi = input_index(input_route_ch3_ch4_next[
            amc_pkg::ROUTE_HI_LSB +: 8]);
        b_lo = input_index(input_route_ch3_ch4_next[
            amc_pkg::ROUTE_LO_LSB +: 8]);
        unique case (mode_act_next)
            amc_pkg::AMC_MODE_SINGLE: begin
                ch_sel_next = {4{a_hi[1:0]}};
                route_ok_next = a_hi[2] && a_hi == a_lo && a_hi == b_hi
                    && a_hi == b_lo;
            end
            amc_pkg::AMC_MODE_DUAL: begin
                ch_sel_next = {b_hi[1:0], a_hi[1:0], b_hi[1:0], a_hi[1:0]};
                route_ok_next = a_hi[2] && b_hi[2] && a_hi == a_lo
                    && b_hi == b_lo;
            end
            default: begin
                ch_sel_next = {b_lo[1:0], b_hi[1:0], a_lo[1:0], a_hi[1:0]};
                route_ok_next = a_hi[2] && a_lo[2] && b_hi[2]
                    && b_lo[2];
            end
        endcase
        if (output_word_format_next == amc_pkg::VAL_FMT_14) begin
            word_bits_next = amc_pkg::BITS_14;
        end else if (output_word_format_next == amc_pkg::VAL_FMT_16) begin
            word_bits_next = amc_pkg::BITS_16;
        end else begin
            word_bits_next = amc_pkg::BITS_12;
        end
    end

    always_ff @(posedge clk_sys) begin
        power_state_ctrl_reg <= power_state_ctrl_next;
        mode_and_clock_divider_reg <= mode_and_clock_divider_next;
        input_route_ch1_ch2_reg <= input_route_ch1_ch2_next;
        input_route_ch3_ch4_reg <= input_route_ch3_ch4_next;
        bit_clock_phase_reg <= bit_clock_phase_next;
        output_word_format_reg <= output_word_format_next;
        pd_state_reg <= pd_state_next;
        mode_act_reg <= mode_act_next;
        div_act_reg <= div_act_next;
        ch_sel_reg <= ch_sel_next;
        route_ok_reg <= route_ok_next;
        word_bits_reg <= word_bits_next;
    end

    // Rate arithmetic: sample rate one stage behind the divider, bit and lclk rates two
    logic [31:0] fs_reg, fs_next;
    logic [31:0] rate_reg, rate_next;
    logic [31:0] lclk_reg, lclk_next;
    logic [3:0] nb_reg, nb_next;

    always_comb begin
        logic [7:0] div_eff;
        div_eff = (div_act_reg == 8'h00) ? 8'h01 : div_act_reg;
        // Divide factor 0 is treated as 1 rather than dividing by zero
        fs_next = CLK_IN_HZ / {24'h000000, div_eff};
        nb_next = 4'(4'h1 << nb_shift(mode_act_reg));
        rate_next = (fs_reg >> nb_shift(mode_act_reg))
            * {27'h0000000, word_bits_reg};
        lclk_next = rate_next >> 1;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            fs_reg <= 32'h00000000;
            nb_reg <= amc_pkg::NB_SINGLE;
            rate_reg <= 32'h00000000;
            lclk_reg <= 32'h00000000;
        end else begin
            fs_reg <= fs_next;
            nb_reg <= nb_next;
            rate_reg <= rate_next;
            lclk_reg <= lclk_next;
        end
    end

    assign power_down = pd_state_reg;
    assign mode_active = mode_act_reg;
    assign clk_div_active = div_act_reg;
    assign mode_divisor = nb_reg;
    assign word_bits = word_bits_reg;
    assign bclk_phase = bit_clock_phase_reg[
        amc_pkg::PHASE_LSB +: amc_pkg::PHASE_W];
    assign ch_input_sel = ch_sel_reg;
    assign route_ok = route_ok_reg;
    assign sample_frequency = fs_reg;
    assign bit_rate = rate_reg;
    assign lclk_rate = lclk_reg;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_write(logic [7:0] a, logic [15:0] d);
        cfg.wr_stb && cfg.addr == a && cfg.data == d;
    endsequence

    sequence s_pin_quiet;
        pd_sync_reg == pd_prev_reg && rstn_sync_reg;
    endsequence

    chk_soft_reset: assert property (
        s_write(amc_pkg::ADDR_SOFT_RESET, amc_pkg::VAL_SOFT_RESET)
        |=> mode_and_clock_divider_reg == amc_pkg::RST_MODE
        && output_word_format_reg == amc_pkg::RST_FORMAT)
        else $error("soft reset did not restore defaults");
    chk_pin_reset: assert property (
        !rstn_sync_reg |=> input_route_ch1_ch2_reg == amc_pkg::RST_ROUTE)
        else $error("reset pin low did not hold defaults");
    chk_pd_enter: assert property (
        s_write(amc_pkg::ADDR_POWER, amc_pkg::VAL_PD_ON) and s_pin_quiet
        |=> power_down)
        else $error("power down write ignored");
    chk_pd_exit: assert property (
        s_write(amc_pkg::ADDR_POWER, amc_pkg::VAL_PD_OFF) and s_pin_quiet
        |=> !power_down)
        else $error("wake write ignored");
    chk_pd_pin: assert property (
        $rose(pd_sync_reg) && rstn_sync_reg |=> power_down)
        else $error("power down pin ignored");
    chk_fmt_14: assert property (
        s_write(amc_pkg::ADDR_FORMAT, amc_pkg::VAL_FMT_14) and s_pin_quiet
        |=> word_bits == amc_pkg::BITS_14 ##1 1'b1)
        else $error("14-bit format not applied");
    chk_route_now: assert property (
        wr_route_a && !soft_rst && rstn_sync_reg
        |=> input_route_ch1_ch2_reg == $past(cfg.data))
        else $error("routing write not applied at once");
    chk_mode_frozen: assert property (
        !power_down && !$past(power_down) && rstn_sync_reg && !soft_rst
        |=> $stable(mode_active))
        else $error("mode changed while active");
    chk_nb_map: assert property (
        $stable(mode_active)[*2] |-> mode_divisor == (
        mode_active == 2'h0 ? amc_pkg::NB_SINGLE :
        mode_active == 2'h1 ? amc_pkg::NB_DUAL : amc_pkg::NB_QUAD))
        else $error("mode divisor mismatch");
    chk_lclk_half: assert property (
        lclk_rate == (bit_rate >> 1))
        else $error("bit clock not half the bit rate");

endmodule // amc_mode_ctrl

// [amc_pkg.sv]
package amc_pkg;

    // Register offsets on the serial configuration port
    localparam logic [7:0] ADDR_SOFT_RESET = 8'h00;
    localparam logic [7:0] ADDR_POWER = 8'h0F;
    localparam logic [7:0] ADDR_MODE = 8'h31;
    localparam logic [7:0] ADDR_ROUTE_A = 8'h3A;
    localparam logic [7:0] ADDR_ROUTE_B = 8'h3B;
    localparam logic [7:0] ADDR_PHASE = 8'h42;
    localparam logic [7:0] ADDR_FORMAT = 8'h53;

    // Command values
    localparam logic [15:0] VAL_SOFT_RESET = 16'h0001;
    localparam logic [15:0] VAL_PD_ON = 16'h0200;
    localparam logic [15:0] VAL_PD_OFF = 16'h0000;
    localparam logic [15:0] VAL_FMT_14 = 16'h0002;
    localparam logic [15:0] VAL_FMT_16 = 16'h0003;

    // Reset values
    localparam logic [15:0] RST_POWER = 16'h0000;
    localparam logic [15:0] RST_MODE = 16'h0001;
    localparam logic [15:0] RST_ROUTE = 16'h0202;
    localparam logic [15:0] RST_PHASE = 16'h0000;
    localparam logic [15:0] RST_FORMAT = 16'h0000;

    // Field positions
    localparam int PD_BIT = 9;
    localparam int MODE_LSB = 8;
    localparam int MODE_W = 2;
    localparam int DIV_LSB = 0;
    localparam int DIV_W = 8;
    localparam int ROUTE_HI_LSB = 8;
    localparam int ROUTE_LO_LSB = 0;
    localparam int PHASE_LSB = 0;
    localparam int PHASE_W = 2;

    // One-hot input codes of a routing byte
    localparam logic [7:0] IN1_CODE = 8'h02;
    localparam logic [7:0] IN2_CODE = 8'h04;
    localparam logic [7:0] IN3_CODE = 8'h08;
    localparam logic [7:0] IN4_CODE = 8'h10;

    // Output word widths
    localparam logic [4:0] BITS_12 = 5'h0C;
    localparam logic [4:0] BITS_14 = 5'h0E;
    localparam logic [4:0] BITS_16 = 5'h10;

    // Mode divisors and their shift amounts
    localparam logic [3:0] NB_SINGLE = 4'h8;
    localparam logic [3:0] NB_DUAL = 4'h4;
    localparam logic [3:0] NB_QUAD = 4'h2;
    localparam logic [1:0] NB_SHIFT_SINGLE = 2'h3;
    localparam logic [1:0] NB_SHIFT_DUAL = 2'h2;
    localparam logic [1:0] NB_SHIFT_QUAD = 2'h1;

    // Serial frame: 8 address bits then 16 data bits, MSB first
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [4:0] FRAME_BITS = 5'h18;

    localparam int CLK_SYS_HZ = 20_000_000;
    localparam int APPLIED_CLK_HZ = 500_000_000;

    typedef enum logic [1:0] {
        AMC_MODE_SINGLE,
        AMC_MODE_DUAL,
        AMC_MODE_QUAD,
        AMC_MODE_PRECISION
    } amc_mode_t;

endpackage

// [amc_cfg_if.sv]
`timescale 1ns/1ps
interface amc_cfg_if;
    logic wr_stb;
    logic [amc_pkg::ADDR_W-1:0] addr;
    logic [amc_pkg::DATA_W-1:0] data;

    modport src (
        output wr_stb,
        output addr,
        output data
    );
    modport dst (
        input wr_stb,
        input addr,
        input data
    );
endinterface

// [amc_spi_rx.sv]
`timescale 1ns/1ps
module amc_spi_rx (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic spi_sclk,
    input wire logic spi_sdata,
    input wire logic spi_cs_n,
    amc_cfg_if.src cfg
);
    logic sclk_meta_reg, sclk_sync_reg, sclk_prev_reg;
    logic sdata_meta_reg, sdata_sync_reg;
    logic cs_n_meta_reg, cs_n_sync_reg, cs_n_prev_reg;
    logic [23:0] shift_reg, shift_next;
    logic [4:0] count_reg, count_next;
    logic wr_reg, wr_next;
    logic [15:0] data_reg, data_next;
    logic [7:0] addr_reg, addr_next;
    logic sclk_rise, cs_rise;

    assign sclk_rise = sclk_sync_reg && !sclk_prev_reg;
    assign cs_rise = cs_n_sync_reg && !cs_n_prev_reg;

    always_comb begin
        shift_next = shift_reg;
        count_next = count_reg;
        wr_next = 1'b0;
        data_next = data_reg;
        addr_next = addr_reg;
        if (cs_n_sync_reg) begin
            count_next = 5'h00;
        end else if (sclk_rise && count_reg <= amc_pkg::FRAME_BITS) begin
            shift_next = {shift_reg[22:0], sdata_sync_reg};
            count_next = count_reg + 5'h01;
        end
        // A frame is committed only when exactly 24 bits preceded the
        // release of select; short or long frames are dropped.
        if (cs_rise && count_reg == amc_pkg::FRAME_BITS) begin
            wr_next = 1'b1;
            addr_next = shift_reg[23:16];
            data_next = shift_reg[15:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        sclk_meta_reg <= spi_sclk;
        sclk_sync_reg <= sclk_meta_reg;
        sdata_meta_reg <= spi_sdata;
        sdata_sync_reg <= sdata_meta_reg;
        cs_n_meta_reg <= spi_cs_n;
        cs_n_sync_reg <= cs_n_meta_reg;
        if (rst) begin
            sclk_prev_reg <= 1'b0;
            cs_n_prev_reg <= 1'b1;
            shift_reg <= 24'h000000;
            count_reg <= 5'h00;
            wr_reg <= 1'b0;
            data_reg <= 16'h0000;
            addr_reg <= 8'h00;
        end else begin
            sclk_prev_reg <= sclk_sync_reg;
            cs_n_prev_reg <= cs_n_sync_reg;
            shift_reg <= shift_next;
            count_reg <= count_next;
            wr_reg <= wr_next;
            data_reg <= data_next;
            addr_reg <= addr_next;
        end
    end

    assign cfg.wr_stb = wr_reg;
    assign cfg.addr = addr_reg;
    assign cfg.data = data_reg;

    chk_frame_commit: assert property (@(posedge clk_sys) disable iff (rst)
        wr_reg |-> $past(count_reg) == amc_pkg::FRAME_BITS)
        else $error("write committed from a frame not 24 bits long");
    chk_strobe_single: assert property (@(posedge clk_sys) disable iff (rst)
        wr_reg |=> !wr_reg)
        else $error("write strobe lasted more than one cycle");

endmodule // amc_spi_rx

// [amc_host_model.sv]
`timescale 1ns/1ps
module amc_host_model (
    input wire logic clk_sys,
    input wire logic start,
    input wire logic [23:0] frame,
    input wire logic [4:0] nbits,
    output logic spi_sclk,
    output logic spi_sdata,
    output logic spi_cs_n,
    output logic busy
);
    initial begin
        spi_sclk = 1'b0;
        spi_sdata = 1'b0;
        spi_cs_n = 1'b1;
        busy = 1'b0;
    end

    // Four cycles per sclk phase stays clear of the three-cycle sync floor
    always @(posedge clk_sys) begin
        if (start) begin
            busy <= 1'b1;
            spi_cs_n <= 1'b0;
            for (int i = 23; i > 23 - int'(nbits); i--) begin
                spi_sdata <= frame[i];
                repeat (4) @(posedge clk_sys);
                spi_sclk <= 1'b1;
                repeat (4) @(posedge clk_sys);
                spi_sclk <= 1'b0;
            end
            repeat (4) @(posedge clk_sys);
            spi_cs_n <= 1'b1;
            // Released line shows the inverse, so a stale bit is never reused
            spi_sdata <= ~spi_sdata;
            repeat (4) @(posedge clk_sys);
            busy <= 1'b0;
        end
    end
endmodule // amc_host_model

// [amc_mode_ctrl_bench.sv]
`timescale 1ns/1ps
module amc_mode_ctrl_bench;
    logic clk_sys, rst, reset_pin_active_low, power_down_pin, start;
    logic [23:0] frame;
    logic [4:0] nbits;
    logic spi_sclk, spi_sdata, spi_cs_n, busy, power_down, route_ok;
    logic [1:0] mode_active, bclk_phase;
    logic [7:0] clk_div_active, ch_input_sel;
    logic [3:0] mode_divisor;
    logic [4:0] word_bits;
    logic [31:0] sample_frequency, bit_rate, lclk_rate;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [15:0] mode_tbl [4] = '{16'h0001, 16'h0102, 16'h0204, 16'h0308};
    logic [31:0] route_tbl [4] = '{32'h10101010, 32'h04040808,
                                   32'h10080402, 32'h02040810};
    logic [7:0] sel_tbl [4] = '{8'hFF, 8'h99, 8'h1B, 8'hE4};

    amc_mode_ctrl u_dut (.clk_sys(clk_sys), .rst(rst),
        .reset_pin_active_low(reset_pin_active_low),
        .power_down_pin(power_down_pin), .spi_sclk(spi_sclk),
        .spi_sdata(spi_sdata), .spi_cs_n(spi_cs_n), .power_down(power_down),
        .mode_active(mode_active), .clk_div_active(clk_div_active),
        .mode_divisor(mode_divisor), .word_bits(word_bits),
        .bclk_phase(bclk_phase), .ch_input_sel(ch_input_sel),
        .route_ok(route_ok), .sample_frequency(sample_frequency),
        .bit_rate(bit_rate), .lclk_rate(lclk_rate));
    amc_host_model u_host (.clk_sys(clk_sys), .start(start), .frame(frame),
        .nbits(nbits), .spi_sclk(spi_sclk), .spi_sdata(spi_sdata),
        .spi_cs_n(spi_cs_n), .busy(busy));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic print_verdict();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // About 26 frames of roughly 207 cycles each are expected
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic spi_wr(input logic [7:0] a, input logic [15:0] d,
                          input logic [4:0] n = 5'h18);
        start <= 1'b1;
        frame <= {a, d};
        nbits <= n;
        @(posedge clk_sys);
        start <= 1'b0;
        do @(posedge clk_sys); while (busy !== 1'b0);
        // Registers land 4 edges after select rises, rates up to 2 later
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic check_rates(input logic [31:0] div, input logic [31:0] nb,
                               input logic [31:0] bits);
        logic [31:0] fs;
        logic [31:0] br;
        fs = amc_pkg::APPLIED_CLK_HZ / div;
        br = fs / nb * bits;
        check(sample_frequency, fs);
        check(mode_divisor, nb);
        check(bit_rate, br);
        check(lclk_rate, br / 32'h2);
    endtask

    initial begin
        rst = 1'b1;
        reset_pin_active_low = 1'b1;
        power_down_pin = 1'b0;
        start = 1'b0;
        frame = 24'h0;
        nbits = 5'h18;
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        repeat (4) @(posedge clk_sys);
        check(power_down, 32'h0);
        check(mode_active, 32'h0);
        check(word_bits, 32'h0C);
        check_rates(32'h1, 32'h8, 32'h0C);
        $display("test defaults done");

        spi_wr(8'h00, 16'h0001);
        spi_wr(8'h0F, 16'h0200);
        check(power_down, 32'h1);
        spi_wr(8'h53, 16'h0002);
        check(word_bits, 32'h0E);
        // 14-bit words carry two bits more than the 12-bit default
        check(word_bits - 5'h0C, 32'h2);
        spi_wr(8'h42, 16'h0002);
        check(bclk_phase, 32'h2);
        spi_wr(8'h31, 16'h0102);
        check(mode_active, 32'h1);
        check(clk_div_active, 32'h2);
        spi_wr(8'h0F, 16'h0000);
        check(power_down, 32'h0);
        spi_wr(8'h3A, 16'h0202);
        spi_wr(8'h3B, 16'h0808);
        check(ch_input_sel, 32'h88);
        check_rates(32'h2, 32'h4, 32'h0E);
        $display("test startup done");

        for (int i = 0; i < 4; i++) begin
            power_down_pin <= 1'b1;
            repeat (6) @(posedge clk_sys);
            check(power_down, 32'h1);
            spi_wr(8'h31, mode_tbl[i]);
            power_down_pin <= 1'b0;
            repeat (6) @(posedge clk_sys);
            check(power_down, 32'h0);
            check(mode_active, 32'(i));
            check(clk_div_active, mode_tbl[i][7:0]);
            spi_wr(8'h3A, route_tbl[i][31:16]);
            spi_wr(8'h3B, route_tbl[i][15:0]);
            check(ch_input_sel, sel_tbl[i]);
            check(route_ok, 32'h1);
            check(power_down, 32'h0);
            check_rates(mode_tbl[i][7:0], 32'h8 >> ((i > 2) ? 2 : i),
                        32'h0E);
        end
        $display("test modes done");

        spi_wr(8'h53, 16'h0003, 5'h17);
        check(word_bits, 32'h0E);
        spi_wr(8'h77, 16'h0003);
        check(word_bits, 32'h0E);
        spi_wr(8'h53, 16'h0003);
        check(word_bits, 32'h10);
        check(word_bits - 5'h0C, 32'h4);
        spi_wr(8'h3A, 16'h0303);
        check(route_ok, 32'h0);
        $display("test refusals done");

        spi_wr(8'h00, 16'h0001);
        check(word_bits, 32'h0C);
        check(route_ok, 32'h1);
        spi_wr(8'h53, 16'h0002);
        reset_pin_active_low <= 1'b0;
        repeat (6) @(posedge clk_sys);
        reset_pin_active_low <= 1'b1;
        repeat (6) @(posedge clk_sys);
        check(word_bits, 32'h0C);
        check(mode_active, 32'h0);
        $display("test resets done");
        print_verdict();
    end
endmodule // amc_mode_ctrl_bench
